// file: boundary_scan_tap.sv
// Notes on behaviour
// RULE1: Five TMS-high clocks reach Test-Logic-Reset.
// RULE2: State moves on rising TCK using TMS.
// RULE3: Test logic self-resets; TRST optional.
// RULE4: Test-Logic-Reset leaves device in normal operation.
// RULE5: Run-Test-Idle acts only for active instructions.
// RULE6: Capture-IR loads pattern ending in 01.
// RULE7: Shift-IR shifts instruction between TDI and TDO.
// RULE8: Update-IR latches instruction on falling TCK.
// RULE9: Capture-DR loads the selected data register.
// RULE10: Instruction is four bits, LSB nearest TDO.
// RULE11: Bypass, boundary, ID paths in parallel.
// RULE12: Bypass stage clears to zero at capture.
// RULE13: Bypass shifting leaves functional operation untouched.
// RULE14: Boundary chain loads and reads I/O cells.
// RULE15: Pause-IR holds instruction path still.
// RULE16: Exit, select states branch per TMS.
// RULE17: Data-path states mirror instruction-path states.
// RULE18: TAP reset after power-up precedes FIFO use.
// RULE19: Decode EXTEST, SAMPLE, IDCODE, HIGHZ, BYPASS.
// RULE20: ID is 32 bits, bit 0 one.
// RULE21: TDO changes on falling TCK, driven in shifts.
module boundary_scan_tap #(
  parameter int BSR_W = 40,
  parameter logic [3:0] ID_VERSION = 4'h0,
  // Arbitrary identity values, not of any real part
  parameter logic [15:0] ID_PART = 16'h1234,
  parameter logic [10:0] ID_MFR = 11'h055
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic trst_n_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  input wire logic [BSR_W-1:0] pin_sample_in,
  output logic [BSR_W-1:0] pin_drive_out,
  output logic extest_out,
  output logic outputs_hiz_out,
  output logic test_reset_out,
  output logic run_idle_out,
  output logic [3:0] instr_out
);
  tap_pkg::tap_pins_t pins;
  tap_pkg::tap_state_t state_r;
  tap_pkg::tap_state_t state_nxt;
  tap_pkg::scan_ctl_t ir_ctl;
  tap_pkg::scan_ctl_t dr_ctl;
  logic tck_d_r;
  logic [3:0] instr_r;
  logic [3:0] ir_par;
  logic [tap_pkg::ID_W-1:0] id_par;
  logic [BSR_W-1:0] bsr_par;
  logic [BSR_W-1:0] upd_r;
  logic ir_so;
  logic id_so;
  logic bsr_so;
  logic byp_r;
  logic tdo_r;
  logic oe_n_r;

  // TCK rests low, the other pins rest high
  tap_sync #(.WIDTH(4), .RESET_VAL(4'h7)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .async_in({tck_in, tms_in, tdi_in, trst_n_in}),
    .sync_out(pins)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= pins.tck;
    end
  end

  wire tck_rise = pins.tck & ~tck_d_r;
  wire tck_fall = ~pins.tck & tck_d_r;
  wire trst_act = ~pins.trst_n;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tap_pkg::ST_RESET: state_nxt = pins.tms ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE; // RULE1
      tap_pkg::ST_IDLE: state_nxt = pins.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      tap_pkg::ST_SEL_DR: state_nxt = pins.tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAPTURE_DR; // RULE16
      tap_pkg::ST_SEL_IR: state_nxt = pins.tms ? tap_pkg::ST_RESET : tap_pkg::ST_CAPTURE_IR; // RULE16
      tap_pkg::ST_CAPTURE_DR: state_nxt = pins.tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_SHIFT_DR: state_nxt = pins.tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_EXIT1_DR: state_nxt = pins.tms ? tap_pkg::ST_UPDATE_DR : tap_pkg::ST_PAUSE_DR; // RULE17
      tap_pkg::ST_PAUSE_DR: state_nxt = pins.tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
      tap_pkg::ST_EXIT2_DR: state_nxt = pins.tms ? tap_pkg::ST_UPDATE_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_UPDATE_DR: state_nxt = pins.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      tap_pkg::ST_CAPTURE_IR: state_nxt = pins.tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_SHIFT_IR: state_nxt = pins.tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_EXIT1_IR: state_nxt = pins.tms ? tap_pkg::ST_UPDATE_IR : tap_pkg::ST_PAUSE_IR; // RULE16
      tap_pkg::ST_PAUSE_IR: state_nxt = pins.tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR; // RULE15
      tap_pkg::ST_EXIT2_IR: state_nxt = pins.tms ? tap_pkg::ST_UPDATE_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_UPDATE_IR: state_nxt = pins.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      default: state_nxt = tap_pkg::ST_RESET;
    endcase
  end

  // System reset stands for power-up, so no TRST is needed
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || trst_act) begin
      state_r <= tap_pkg::ST_RESET; // RULE3 RULE18
    end else if (tck_rise) begin
      state_r <= state_nxt; // RULE2
    end
  end

  // Capture and shift strobes fire on the rising edge that leaves the named state, update strobes on the falling edge inside it
  assign ir_ctl.capture = tck_rise && state_r == tap_pkg::ST_CAPTURE_IR; // RULE6
  assign ir_ctl.shift = tck_rise && state_r == tap_pkg::ST_SHIFT_IR; // RULE7 RULE15
  assign ir_ctl.update = tck_fall && state_r == tap_pkg::ST_UPDATE_IR; // RULE8
  assign dr_ctl.capture = tck_rise && state_r == tap_pkg::ST_CAPTURE_DR; // RULE9
  assign dr_ctl.shift = tck_rise && state_r == tap_pkg::ST_SHIFT_DR; // RULE17
  assign dr_ctl.update = tck_fall && state_r == tap_pkg::ST_UPDATE_DR;

  wire sel_bsr = instr_r == tap_pkg::OP_EXTEST || instr_r == tap_pkg::OP_SAMPLE; // RULE19
  wire sel_id = instr_r == tap_pkg::OP_IDCODE; // RULE19
  // Unknown codes fall back to bypass
  wire sel_byp = !sel_bsr && !sel_id; // RULE11 RULE19

  tap_shift_reg #(.WIDTH(tap_pkg::IR_W)) u_ir (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .capture_in(ir_ctl.capture),
    .shift_in(ir_ctl.shift),
    .load_in(tap_pkg::IR_CAPTURE), // RULE6
    .serial_in(pins.tdi),
    .serial_out(ir_so), // RULE10
    .par_out(ir_par)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || trst_act || state_r == tap_pkg::ST_RESET) begin
      instr_r <= tap_pkg::IR_RESET;
    end else if (ir_ctl.update) begin
      instr_r <= ir_par; // RULE8
    end
  end

  assign id_par = {ID_VERSION, ID_PART, ID_MFR, 1'b1}; // RULE20

  tap_shift_reg #(.WIDTH(tap_pkg::ID_W)) u_id (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .capture_in(dr_ctl.capture && sel_id), // RULE9
    .shift_in(dr_ctl.shift && sel_id),
    .load_in(id_par),
    .serial_in(pins.tdi),
    .serial_out(id_so),
    .par_out()
  );

  tap_shift_reg #(.WIDTH(BSR_W)) u_bsr (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .capture_in(dr_ctl.capture && sel_bsr), // RULE14
    .shift_in(dr_ctl.shift && sel_bsr),
    .load_in(pin_sample_in),
    .serial_in(pins.tdi),
    .serial_out(bsr_so),
    .par_out(bsr_par)
  );

  // Bypass touches nothing outside its own stage
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      byp_r <= 1'b0;
    end else if (dr_ctl.capture && sel_byp) begin
      byp_r <= 1'b0; // RULE12
    end else if (dr_ctl.shift && sel_byp) begin
      byp_r <= pins.tdi; // RULE13
    end
  end

  // Preloaded cell values, on pin_drive_out under every instruction; extest_out flags EXTEST
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      upd_r <= '0;
    end else if (dr_ctl.update && sel_bsr) begin
      upd_r <= bsr_par; // RULE14
    end
  end

  wire in_reset = state_r == tap_pkg::ST_RESET;
  wire shifting = state_r == tap_pkg::ST_SHIFT_IR || state_r == tap_pkg::ST_SHIFT_DR;
  wire dr_so = sel_id ? id_so : (sel_bsr ? bsr_so : byp_r); // RULE11
  wire tdo_nxt = state_r == tap_pkg::ST_SHIFT_IR ? ir_so : dr_so;

  always_ff @(posedge clk_sys_in) begin
    // TRST in mid-shift must release TDO at once, not at the next TCK fall
    if (!rst_n_in || trst_act) begin
      tdo_r <= 1'b1;
      oe_n_r <= 1'b1; // RULE21
    end else if (tck_fall) begin
      tdo_r <= tdo_nxt; // RULE21
      oe_n_r <= ~shifting; // RULE21
    end
  end

  assign tdo_out = tdo_r;
  assign tdo_oe_n_out = oe_n_r;
  assign pin_drive_out = upd_r;
  assign extest_out = !in_reset && instr_r == tap_pkg::OP_EXTEST; // RULE4
  assign outputs_hiz_out = !in_reset && instr_r == tap_pkg::OP_HIGHZ; // RULE4
  assign test_reset_out = in_reset; // RULE4
  // No instruction here uses Run-Test-Idle, so it stays a plain status
  assign run_idle_out = state_r == tap_pkg::ST_IDLE; // RULE5
  assign instr_out = instr_r;
endmodule

// file: jtag_tester.sv
module jtag_tester (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trst_n_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_n_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tdo_s = 1'h0;
  initial begin
    tck_out = 1'h0;
    tms_out = 1'h1;
    tdi_out = 1'h0;
    trst_n_out = 1'h1;
  end
  // TCK rests low between steps; a released TDO reads as the inverse of the last bit
  task automatic step(input logic tms, input logic tdi);
    tms_out = tms;
    tdi_out = tdi;
    #62.5;
    tdo_s = tdo_oe_n_in ? ~tdo_s : tdo_in;
    tck_out = 1'h1;
    #62.5;
    tck_out = 1'h0;
  endtask
  task automatic walk(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++) step(seq[i], ~tdi_out);
  endtask
  task automatic reset5();
    walk(8'hff, 5);
  endtask
  task automatic scan(input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = 64'h0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = tdo_s;
    end
  endtask
  task automatic ir_scan(input logic [3:0] op, output logic [3:0] cap);
    logic [63:0] a;
    logic [63:0] b;
    walk(8'h03, 4);
    scan(3, {61'h0, op[2:0]}, a);
    walk(8'h04, 4);
    scan(1, {63'h0, op[3]}, b);
    walk(8'h01, 2);
    cap = {b[0], a[2:0]};
  endtask
  task automatic dr_scan(input int n, input logic [63:0] din, output logic [63:0] dout);
    walk(8'h01, 3);
    scan(n, din, dout);
    walk(8'h01, 2);
  endtask
endmodule

// file: tap_pkg.sv
package tap_pkg;

  // Controller states, standard encoding
  typedef enum logic [3:0] {
    ST_EXIT2_DR = 4'h0,
    ST_EXIT1_DR = 4'h1,
    ST_SHIFT_DR = 4'h2,
    ST_PAUSE_DR = 4'h3,
    ST_SEL_IR = 4'h4,
    ST_UPDATE_DR = 4'h5,
    ST_CAPTURE_DR = 4'h6,
    ST_SEL_DR = 4'h7,
    ST_EXIT2_IR = 4'h8,
    ST_EXIT1_IR = 4'h9,
    ST_SHIFT_IR = 4'ha,
    ST_PAUSE_IR = 4'hb,
    ST_IDLE = 4'hc,
    ST_UPDATE_IR = 4'hd,
    ST_CAPTURE_IR = 4'he,
    ST_RESET = 4'hf
  } tap_state_t;

  localparam int IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h2;
  localparam logic [3:0] OP_HIGHZ = 4'h3;
  localparam logic [3:0] OP_BYPASS = 4'hf;
  // Reset leaves the identification path selected
  localparam logic [3:0] IR_RESET = OP_IDCODE;

  localparam int ID_W = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;

  // Pin group from the tester after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_t;

  // Decoded controller actions, one-cycle strobes on clk_sys_in
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } scan_ctl_t;

endpackage

// file: tap_properties.sv
module tap_properties #(
  parameter int BSR_W = 40
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_n_out,
  input wire logic [BSR_W-1:0] pin_drive_out,
  input wire logic extest_out,
  input wire logic outputs_hiz_out,
  input wire logic test_reset_out,
  input wire logic run_idle_out,
  input wire logic [3:0] instr_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  reset_values_a: assert property (disable iff (1'b0) !rst_n_in |=> test_reset_out &&
    instr_out == tap_pkg::IR_RESET && tdo_oe_n_out) else $error("reset values wrong");
  state_exclusive_a: assert property (!(test_reset_out && run_idle_out))
    else $error("reset and idle together");
  extest_decode_a: assert property ($stable(instr_out) && !test_reset_out |->
    extest_out == (instr_out == tap_pkg::OP_EXTEST)) else $error("extest decode wrong");
  hiz_decode_a: assert property ($stable(instr_out) && !test_reset_out |->
    outputs_hiz_out == (instr_out == tap_pkg::OP_HIGHZ)) else $error("highz decode wrong");
  instr_update_a: assert property ($changed(instr_out) |-> !run_idle_out)
    else $error("instruction changed in idle");
  drive_hold_a: assert property (run_idle_out && $past(run_idle_out) |->
    $stable(pin_drive_out)) else $error("boundary outputs moved in idle");
  tdo_enable_a: assert property (!tdo_oe_n_out |-> !run_idle_out && !test_reset_out)
    else $error("tdo driven outside shift");
  tdo_edge_a: assert property ($changed(tdo_out) |-> !tck_in)
    else $error("tdo moved while tck high");
  idle_entry_a: assert property ($rose(run_idle_out) |-> tck_in)
    else $error("state moved without tck rise");
  cover property (run_idle_out);
  cover property (extest_out);
  cover property (outputs_hiz_out);
  cover property (!tdo_oe_n_out);
endmodule
bind boundary_scan_tap tap_properties #(.BSR_W(BSR_W)) chk (.clk_sys_in, .rst_n_in, .tck_in,
  .tdo_out, .tdo_oe_n_out, .pin_drive_out, .extest_out, .outputs_hiz_out, .test_reset_out,
  .run_idle_out, .instr_out);

// file: tap_shift_reg.sv
module tap_shift_reg #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic capture_in,
  input wire logic shift_in,
  input wire logic [WIDTH-1:0] load_in,
  input wire logic serial_in,
  output logic serial_out,
  output logic [WIDTH-1:0] par_out
);
  logic [WIDTH-1:0] sh_r;
  logic [WIDTH-1:0] sh_nxt;

  // LSB sits nearest the serial output
  assign sh_nxt = capture_in ? load_in :
                  shift_in ? {serial_in, sh_r[WIDTH-1:1]} : sh_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sh_r <= '0;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  assign serial_out = sh_r[0];
  assign par_out = sh_r;
endmodule

// file: tap_sync.sv
module tap_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // Reset to each pin's resting level, so no false edge follows reset
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

// file: tb_boundary_scan_tap.sv
module tb_boundary_scan_tap;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] VER = 4'h3;
  // Arbitrary identity values
  localparam logic [15:0] PART = 16'h5a6c;
  localparam logic [10:0] MFR = 11'h2b1;
  logic clk_sys_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [39:0] pin_sample_in = 40'h0;
  logic tck_in, tms_in, tdi_in, trst_n_in, tdo_out, tdo_oe_n_out;
  logic [39:0] pin_drive_out;
  logic extest_out, outputs_hiz_out, test_reset_out, run_idle_out;
  logic [3:0] instr_out;
  int miscompares = 0;
  int total_checks = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  boundary_scan_tap #(.BSR_W(40), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) dut (
    .clk_sys_in, .rst_n_in, .tck_in, .tms_in, .tdi_in, .trst_n_in, .tdo_out, .tdo_oe_n_out,
    .pin_sample_in, .pin_drive_out, .extest_out, .outputs_hiz_out, .test_reset_out,
    .run_idle_out, .instr_out);
  jtag_tester tester (.tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in),
    .trst_n_out(trst_n_in), .tdo_in(tdo_out), .tdo_oe_n_in(tdo_oe_n_out));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (6) @(negedge clk_sys_in);
  endtask
  task automatic t_reset();
    check("test_reset", test_reset_out, 1'h1);
    check("instr", instr_out, tap_pkg::IR_RESET);
    check("tdo_oe_n", tdo_oe_n_out, 1'h1);
    tester.step(1'h0, 1'h0);
    settle();
    check("run_idle", run_idle_out, 1'h1);
  endtask
  task automatic t_idcode();
    logic [63:0] o;
    logic [63:0] p;
    tester.dr_scan(32, 64'h0, o);
    check("idcode", o, {32'h0, VER, PART, MFR, 1'h1});
    tester.walk(8'h01, 3);
    tester.scan(16, 64'h0, o);
    tester.walk(8'h04, 4);
    tester.scan(16, 64'h0, p);
    tester.walk(8'h01, 2);
    check("idcode_paused", {p[15:0], o[15:0]}, {VER, PART, MFR, 1'h1});
  endtask
  task automatic t_ir();
    logic [3:0] ops [6] = '{tap_pkg::OP_EXTEST, tap_pkg::OP_SAMPLE, tap_pkg::OP_IDCODE,
      tap_pkg::OP_HIGHZ, tap_pkg::OP_BYPASS, 4'h7};
    logic [3:0] cap;
    logic [63:0] o;
    foreach (ops[i]) begin
      tester.ir_scan(ops[i], cap);
      settle();
      check("ir_capture", cap, tap_pkg::IR_CAPTURE);
      check("instr", instr_out, ops[i]);
      check("extest", extest_out, ops[i] == tap_pkg::OP_EXTEST);
      check("hiz", outputs_hiz_out, ops[i] == tap_pkg::OP_HIGHZ);
      if (i > 2) begin
        tester.dr_scan(8, 64'ha5, o);
        check("bypass", o, 64'h4a);
        check("pin_drive", pin_drive_out, 40'h0);
      end
    end
  endtask
  task automatic t_bsr();
    logic [3:0] cap;
    logic [63:0] o;
    pin_sample_in = 40'h9c12345e71;
    tester.ir_scan(tap_pkg::OP_SAMPLE, cap);
    tester.dr_scan(40, 64'h5af00f3c21, o);
    settle();
    check("bsr_capture", o, {24'h0, pin_sample_in});
    check("pin_drive", pin_drive_out, 40'h5af00f3c21);
    tester.ir_scan(tap_pkg::OP_EXTEST, cap);
    settle();
    check("extest", extest_out, 1'h1);
    check("pin_drive", pin_drive_out, 40'h5af00f3c21);
  endtask
  task automatic t_tms_reset();
    tester.walk(8'h01, 3);
    tester.reset5();
    settle();
    check("test_reset", test_reset_out, 1'h1);
    check("instr", instr_out, tap_pkg::IR_RESET);
    check("extest", extest_out, 1'h0);
  endtask
  task automatic t_trst();
    tester.walk(8'h02, 4);
    settle();
    check("tdo_oe_n", tdo_oe_n_out, 1'h0);
    tester.trst_n_out = 1'h0;
    settle();
    check("test_reset", test_reset_out, 1'h1);
    check("tdo_oe_n", tdo_oe_n_out, 1'h1);
    check("instr", instr_out, tap_pkg::IR_RESET);
    tester.trst_n_out = 1'h1;
    settle();
    tester.step(1'h0, 1'h0);
    settle();
    check("run_idle", run_idle_out, 1'h1);
  endtask
  initial begin
    repeat (12) @(negedge clk_sys_in);
    rst_n_in = 1'h1;
    settle();
    t_reset();
    t_idcode();
    t_ir();
    t_bsr();
    t_tms_reset();
    t_trst();
    give_verdict();
  end
  initial begin
    #500us;
    miscompares++;
    give_verdict();
  end
endmodule
